// >>> verilog/source_offset_status_error_cmd.sv
`timescale 1ns/1ns
// What this block does
// - Store 0 to 2.50 V offset, read back
// - Offset applied only while offset state on
// - State accepts 1 or 0, reads 1 or 0
// - Refuse offset on in gated drive mode
// - Free running mode drives signal always
// - Gated mode drives during measurement, forces offset off
// - Condition register reads as 15 bit value
// - Mask written 0..65535, reads back 15 bits
// - Out of range mask rejected, error raised
// - Zero mask blocks all operation events
// - Event register reads latched 15 bit events
// - Error read gives signed number, zero none
// - Errors delivered oldest first
// - Read error entry leaves the queue
// - At most sixteen queued errors
// - Full queue: last entry becomes overflow, drop rest
module source_offset_status_error_cmd
    import offs_stat_pkg::*;
#(
    parameter int DEPTH = ERR_DEPTH
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [14:0] condition_in,
    input wire logic measuring_in,
    input wire logic [15:0] ext_err_code,
    input wire logic ext_err_valid,
    output logic [8:0] offset_applied,
    output logic drive_enable,
    output logic irq
);
    localparam int PW = $clog2(DEPTH);

    logic [14:0] cond_s1_ff, cond_ff, cond_prev_ff;
    logic meas_s1_ff, meas_ff;
    logic aw_ff, w_ff;
    logic [7:0] awaddr_ff;
    logic [31:0] wdata_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [8:0] offset_ff;
    logic offset_on_ff;
    drive_mode_t mode_ff;
    logic [14:0] mask_ff;
    logic [14:0] event_ff;
    logic [15:0] errq [DEPTH];
    logic [PW-1:0] rd_ptr_ff, wr_ptr_ff;
    logic [PW:0] count_ff;
    logic [2:0] irq_stat_ff, irq_mask_ff;

    logic wr_fire, rd_fire;
    logic [31:0] wval;
    logic err_set;
    logic [15:0] err_code;
    logic pop;
    logic [14:0] rise;
    logic event_rd, stat_rd, ovf_push;

    // Status lines come from other logic domains; settle them first
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cond_s1_ff <= '0;
            cond_ff <= '0;
            meas_s1_ff <= 1'b0;
            meas_ff <= 1'b0;
            cond_prev_ff <= '0;
        end
        else
        begin
            cond_s1_ff <= condition_in;
            cond_ff <= cond_s1_ff;
            meas_s1_ff <= measuring_in;
            meas_ff <= meas_s1_ff;
            cond_prev_ff <= cond_ff;
        end
    end

    // Write channel: address and data accepted in either order
    assign s_axi_awready = !aw_ff && !bvalid_ff;
    assign s_axi_wready = !w_ff && !bvalid_ff;
    assign wr_fire = aw_ff && w_ff && !bvalid_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_ff <= 1'b0;
            w_ff <= 1'b0;
            awaddr_ff <= '0;
            wdata_ff <= '0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end
            else if (wr_fire)
                aw_ff <= 1'b0;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
            end
            else if (wr_fire)
                w_ff <= 1'b0;
        end
    end

    // Strobes: the whole word is written; partial strobes are taken as whole
    assign wval = wdata_ff;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
        end
        else if (wr_fire)
        begin
            bvalid_ff <= 1'b1;
            case (awaddr_ff)
                OFFSET_VALUE_ADDR, OFFSET_STATE_ADDR, DRIVE_MODE_ADDR,
                EVENT_MASK_ADDR, ERROR_PUSH_ADDR, IRQ_MASK_ADDR:
                    bresp_ff <= RESP_OKAY;
                default:
                    bresp_ff <= RESP_SLVERR;
            endcase
        end
        else if (s_axi_bready)
            bvalid_ff <= 1'b0;
    end

    // Settings and the rejections that raise errors
    always_comb
    begin
        err_set = 1'b0;
        err_code = ERR_NONE;
        if (wr_fire)
        begin
            case (awaddr_ff)
                OFFSET_VALUE_ADDR:
                    if (wval > {23'h0, OFFSET_MAX})
                    begin
                        err_set = 1'b1;
                        err_code = ERR_DATA_RANGE;
                    end
                OFFSET_STATE_ADDR:
                    if (wval > 32'h1)
                    begin
                        err_set = 1'b1;
                        err_code = ERR_DATA_RANGE;
                    end
                    else if (wval[0] && mode_ff == MEASURE_GATED_DRIVE)
                    begin
                        err_set = 1'b1;
                        err_code = ERR_SETTINGS_CONFLICT;
                    end
                DRIVE_MODE_ADDR:
                    if (wval > 32'h1)
                    begin
                        err_set = 1'b1;
                        err_code = ERR_DATA_RANGE;
                    end
                EVENT_MASK_ADDR:
                    if (wval > MASK_WRITE_MAX)
                    begin
                        err_set = 1'b1;
                        err_code = ERR_DATA_RANGE;
                    end
                ERROR_PUSH_ADDR:
                    if (wval[15:0] != ERR_NONE)
                    begin
                        err_set = 1'b1;
                        err_code = wval[15:0];
                    end
                default:
                begin
                    err_set = 1'b0;
                    err_code = ERR_NONE;
                end
            endcase
        end
        else if (ext_err_valid && ext_err_code != ERR_NONE)
        begin
            err_set = 1'b1;
            err_code = ext_err_code;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            offset_ff <= '0;
            offset_on_ff <= 1'b0;
            mode_ff <= FREE_RUNNING_DRIVE;
            mask_ff <= '0;
            irq_mask_ff <= '0;
        end
        else if (wr_fire && !err_set)
        begin
            case (awaddr_ff)
                OFFSET_VALUE_ADDR:
                    offset_ff <= wval[8:0];
                OFFSET_STATE_ADDR:
                    offset_on_ff <= wval[0];
                DRIVE_MODE_ADDR:
                begin
                    mode_ff <= drive_mode_t'(wval[0]);
                    if (wval[0])
                        offset_on_ff <= 1'b0;
                end
                EVENT_MASK_ADDR:
                    mask_ff <= wval[14:0];
                IRQ_MASK_ADDR:
                    irq_mask_ff <= wval[2:0];
                default:
                    mask_ff <= mask_ff;
            endcase
        end
    end

    assign offset_applied = offset_on_ff ? offset_ff : 9'h000;
    assign drive_enable = (mode_ff == FREE_RUNNING_DRIVE) || meas_ff;

    // Rising condition bits latch as events, gated by the mask
    assign rise = cond_ff & ~cond_prev_ff & mask_ff;
    assign rd_fire = s_axi_arvalid && s_axi_arready;
    assign event_rd = rd_fire && s_axi_araddr == EVENT_LATCH_ADDR;
    assign stat_rd = rd_fire && s_axi_araddr == IRQ_STATUS_ADDR;
    assign pop = rd_fire && s_axi_araddr == ERROR_POP_ADDR && count_ff != 0;

    // New events in the read cycle survive the clear
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            event_ff <= '0;
        else if (event_rd)
            event_ff <= rise;
        else
            event_ff <= event_ff | rise;
    end

    // Error queue; the last free slot is kept for the overflow marker
    assign ovf_push = err_set && count_ff == (PW+1)'(DEPTH - 1) && !pop;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rd_ptr_ff <= '0;
            wr_ptr_ff <= '0;
            count_ff <= '0;
        end
        else
        begin
            if (pop)
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
            if (err_set && (count_ff < (PW+1)'(DEPTH) || pop))
            begin
                errq[wr_ptr_ff] <= ovf_push ? ERR_QUEUE_OVERFLOW : err_code;
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
                if (!pop)
                    count_ff <= count_ff + 1'b1;
            end
            else if (pop)
                count_ff <= count_ff - 1'b1;
        end
    end

    // Interrupt status: set wins over the read clear
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            irq_stat_ff <= '0;
        else
            irq_stat_ff <= (stat_rd ? 3'b000 : irq_stat_ff)
                | {ovf_push, |rise, err_set};
    end
    assign irq = |(irq_stat_ff & irq_mask_ff);

    // Read channel
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_ff <= 1'b0;
            rdata_ff <= '0;
            s_axi_rresp <= RESP_OKAY;
        end
        else if (rd_fire)
        begin
            rvalid_ff <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            case (s_axi_araddr)
                OFFSET_VALUE_ADDR: rdata_ff <= {23'h0, offset_ff};
                OFFSET_STATE_ADDR: rdata_ff <= {31'h0, offset_on_ff};
                DRIVE_MODE_ADDR: rdata_ff <= {31'h0, mode_ff};
                COND_REG_ADDR: rdata_ff <= {17'h0, cond_ff};
                EVENT_MASK_ADDR:
                    rdata_ff <= {17'h0, mask_ff & MASK_READ_FIELD};
                EVENT_LATCH_ADDR: rdata_ff <= {17'h0, event_ff};
                ERROR_POP_ADDR:
                    rdata_ff <= (count_ff != 0)
                        ? {{16{errq[rd_ptr_ff][15]}}, errq[rd_ptr_ff]}
                        : 32'h0000_0000;
                IRQ_STATUS_ADDR: rdata_ff <= {29'h0, irq_stat_ff};
                IRQ_MASK_ADDR: rdata_ff <= {29'h0, irq_mask_ff};
                ERROR_COUNT_ADDR: rdata_ff <= {{(31-PW){1'b0}}, count_ff};
                default:
                begin
                    rdata_ff <= '0;
                    s_axi_rresp <= RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rready)
            rvalid_ff <= 1'b0;
    end

    a_gated_forces_off: assert property (@(posedge aclk) disable iff (!aresetn)
        mode_ff == MEASURE_GATED_DRIVE |-> !offset_on_ff)
        else $error("offset on in gated mode");
    a_offset_applied: assert property (@(posedge aclk) disable iff (!aresetn)
        !offset_on_ff |-> offset_applied == 9'h000)
        else $error("offset applied while off");
    a_offset_range: assert property (@(posedge aclk) disable iff (!aresetn)
        offset_ff <= OFFSET_MAX)
        else $error("offset beyond limit");
    a_free_drive: assert property (@(posedge aclk) disable iff (!aresetn)
        mode_ff == FREE_RUNNING_DRIVE |-> drive_enable)
        else $error("free running drive stopped");
    a_gated_drive: assert property (@(posedge aclk) disable iff (!aresetn)
        mode_ff == MEASURE_GATED_DRIVE |-> drive_enable == meas_ff)
        else $error("gated drive mismatch");
    a_mask_keep: assert property (@(posedge aclk) disable iff (!aresetn)
        wr_fire && awaddr_ff == EVENT_MASK_ADDR && wval > MASK_WRITE_MAX
        |=> $stable(mask_ff))
        else $error("bad mask stored");
    a_event_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        event_rd && rise == 15'h0 |=> event_ff == 15'h0)
        else $error("event not cleared on read");
    a_queue_depth: assert property (@(posedge aclk) disable iff (!aresetn)
        count_ff <= (PW+1)'(DEPTH))
        else $error("queue over depth");
    a_zero_mask: assert property (@(posedge aclk) disable iff (!aresetn)
        mask_ff == 15'h0 && !event_rd |=> event_ff == $past(event_ff))
        else $error("event with zero mask");
    c_overflow: cover property (@(posedge aclk) disable iff (!aresetn)
        ovf_push);
    c_error_pop: cover property (@(posedge aclk) disable iff (!aresetn) pop);
    c_refuse_on: cover property (@(posedge aclk) disable iff (!aresetn)
        wr_fire && err_code == ERR_SETTINGS_CONFLICT);
endmodule

// >>> inc/offs_stat_pkg.sv
package offs_stat_pkg;
    // Register byte offsets
    localparam logic [7:0] OFFSET_VALUE_ADDR = 8'h00;
    localparam logic [7:0] OFFSET_STATE_ADDR = 8'h04;
    localparam logic [7:0] DRIVE_MODE_ADDR = 8'h08;
    localparam logic [7:0] COND_REG_ADDR = 8'h0c;
    localparam logic [7:0] EVENT_MASK_ADDR = 8'h10;
    localparam logic [7:0] EVENT_LATCH_ADDR = 8'h14;
    localparam logic [7:0] ERROR_POP_ADDR = 8'h18;
    localparam logic [7:0] ERROR_PUSH_ADDR = 8'h1c;
    localparam logic [7:0] IRQ_STATUS_ADDR = 8'h20;
    localparam logic [7:0] IRQ_MASK_ADDR = 8'h24;
    localparam logic [7:0] ERROR_COUNT_ADDR = 8'h28;
    // Offset in units of 0.01 V, 0 .. 2.50 V
    localparam logic [8:0] OFFSET_MAX = 9'h0fa;
    localparam logic [31:0] MASK_WRITE_MAX = 32'h0000ffff;
    localparam logic [14:0] MASK_READ_FIELD = 15'h7fff;
    // Error codes raised by this block itself (signed 16 bit)
    localparam logic [15:0] ERR_NONE = 16'h0000;
    localparam logic [15:0] ERR_DATA_RANGE = 16'hff9e;
    localparam logic [15:0] ERR_SETTINGS_CONFLICT = 16'hff29;
    localparam logic [15:0] ERR_QUEUE_OVERFLOW = 16'hfebe;
    localparam int ERR_DEPTH = 16;
    // Interrupt status bits
    localparam int IRQ_ERR_BIT = 0;
    localparam int IRQ_EVENT_BIT = 1;
    localparam int IRQ_OVF_BIT = 2;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    typedef enum logic {FREE_RUNNING_DRIVE, MEASURE_GATED_DRIVE} drive_mode_t;
endpackage

// >>> sim/host_model.sv
`timescale 1ns/1ns
module host_model
(
    input wire logic aclk,
    output logic [7:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    output logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    output logic bready,
    output logic [7:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    initial
    begin
        {awaddr, awvalid, wdata, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
        wstrb = 4'hf;
    end

    // Released payload is inverted so stale values never look valid
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw_ok && w_ok))
        begin
            @(posedge aclk);
            if (!aw_ok && awready)
            begin
                aw_ok = 1'b1;
                awvalid <= 1'b0;
                awaddr <= ~a;
            end
            if (!w_ok && wready)
            begin
                w_ok = 1'b1;
                wvalid <= 1'b0;
                wdata <= ~d;
            end
        end
        while (!bvalid)
            @(posedge aclk);
        r = bresp;
        bready <= 1'b0;
        // One idle edge so a following call never re-drives bready here
        @(posedge aclk);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
            @(posedge aclk);
        while (!arready);
        arvalid <= 1'b0;
        araddr <= ~a;
        while (!rvalid)
            @(posedge aclk);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        @(posedge aclk);
    endtask
endmodule

// >>> sim/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    import offs_stat_pkg::*;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, measuring_in, ext_err_valid;
    logic drive_enable, irq;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [14:0] condition_in;
    logic [15:0] ext_err_code;
    logic [8:0] offset_applied;
    int errors = 0;
    int n_checks = 0;
    int cycles = 0;
    logic [31:0] early_errs [4] = '{32'hffffff9e, 32'hffffff9e,
                                    32'hffffff29, 32'hffffff9e};

    source_offset_status_error_cmd #(.DEPTH(16)) dut (.aclk(aclk),
        .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .condition_in(condition_in), .measuring_in(measuring_in),
        .ext_err_code(ext_err_code), .ext_err_valid(ext_err_valid),
        .offset_applied(offset_applied), .drive_enable(drive_enable),
        .irq(irq));

    host_model host (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

    initial
    begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Hang guard well above the few hundred cycles the tests need
    always @(posedge aclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            $display("CHECK FAILED t=%0t timeout", $time);
            summarize();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what,
                     got, exp);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                          input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        host.rd(a, d, r);
        check({30'h0, r}, {30'h0, er}, "rresp");
        if (er === RESP_OKAY)
            check(d, exp, "rdata");
    endtask

    task automatic wr_chk(input logic [7:0] a, input logic [31:0] d,
                          input logic [1:0] er);
        logic [1:0] r;
        host.wr(a, d, r);
        check({30'h0, r}, {30'h0, er}, "bresp");
    endtask

    task automatic waitc(input int n);
        repeat (n) @(posedge aclk);
    endtask

    initial
    begin
        aresetn = 1'b0;
        condition_in = 15'h0000;
        measuring_in = 1'b0;
        ext_err_code = 16'h0000;
        ext_err_valid = 1'b0;
        waitc(8);
        aresetn <= 1'b1;
        @(posedge aclk);
        check({31'h0, drive_enable}, 32'h1, "drive at reset");
        rd_chk(OFFSET_VALUE_ADDR, 32'h0, RESP_OKAY);
        rd_chk(DRIVE_MODE_ADDR, 32'h0, RESP_OKAY);
        wr_chk(OFFSET_VALUE_ADDR, 32'h0fa, RESP_OKAY);
        rd_chk(OFFSET_VALUE_ADDR, 32'h0fa, RESP_OKAY);
        check({23'h0, offset_applied}, 32'h0, "offset while off");
        wr_chk(OFFSET_VALUE_ADDR, 32'h0fb, RESP_OKAY);
        rd_chk(OFFSET_VALUE_ADDR, 32'h0fa, RESP_OKAY);
        wr_chk(OFFSET_STATE_ADDR, 32'h1, RESP_OKAY);
        rd_chk(OFFSET_STATE_ADDR, 32'h1, RESP_OKAY);
        check({23'h0, offset_applied}, 32'h0fa, "offset on");
        wr_chk(OFFSET_STATE_ADDR, 32'h2, RESP_OKAY);
        rd_chk(OFFSET_STATE_ADDR, 32'h1, RESP_OKAY);
        $display("test offset done");

        wr_chk(DRIVE_MODE_ADDR, 32'h1, RESP_OKAY);
        rd_chk(OFFSET_STATE_ADDR, 32'h0, RESP_OKAY);
        check({23'h0, offset_applied}, 32'h0, "gated offset");
        wr_chk(OFFSET_STATE_ADDR, 32'h1, RESP_OKAY);
        rd_chk(OFFSET_STATE_ADDR, 32'h0, RESP_OKAY);
        rd_chk(DRIVE_MODE_ADDR, 32'h1, RESP_OKAY);
        measuring_in <= 1'b1;
        waitc(4);
        check({31'h0, drive_enable}, 32'h1, "gated measuring");
        measuring_in <= 1'b0;
        waitc(4);
        check({31'h0, drive_enable}, 32'h0, "gated idle");
        wr_chk(DRIVE_MODE_ADDR, 32'h0, RESP_OKAY);
        waitc(1);
        check({31'h0, drive_enable}, 32'h1, "free running");
        $display("test drive mode done");

        wr_chk(IRQ_MASK_ADDR, 32'h2, RESP_OKAY);
        wr_chk(EVENT_MASK_ADDR, 32'h0, RESP_OKAY);
        condition_in <= 15'h1234;
        waitc(4);
        rd_chk(COND_REG_ADDR, 32'h1234, RESP_OKAY);
        rd_chk(EVENT_LATCH_ADDR, 32'h0, RESP_OKAY);
        check({31'h0, irq}, 32'h0, "irq no event");
        wr_chk(EVENT_MASK_ADDR, 32'hffff, RESP_OKAY);
        rd_chk(EVENT_MASK_ADDR, 32'h7fff, RESP_OKAY);
        wr_chk(EVENT_MASK_ADDR, 32'h10000, RESP_OKAY);
        rd_chk(EVENT_MASK_ADDR, 32'h7fff, RESP_OKAY);
        condition_in <= 15'h0000;
        waitc(4);
        condition_in <= 15'h0001;
        waitc(4);
        check({31'h0, irq}, 32'h1, "irq on event");
        rd_chk(EVENT_LATCH_ADDR, 32'h1, RESP_OKAY);
        rd_chk(EVENT_LATCH_ADDR, 32'h0, RESP_OKAY);
        rd_chk(IRQ_STATUS_ADDR, 32'h3, RESP_OKAY);
        check({31'h0, irq}, 32'h0, "irq cleared");
        rd_chk(8'h3c, 32'h0, RESP_SLVERR);
        wr_chk(8'h3c, 32'h0, RESP_SLVERR);
        $display("test status done");

        foreach (early_errs[i])
            rd_chk(ERROR_POP_ADDR, early_errs[i], RESP_OKAY);
        rd_chk(ERROR_POP_ADDR, 32'h0, RESP_OKAY);
        for (int i = 1; i <= 20; i++)
        begin
            ext_err_code <= 16'(i);
            ext_err_valid <= 1'b1;
            @(posedge aclk);
            ext_err_valid <= 1'b0;
            @(posedge aclk);
        end
        check({31'h0, irq}, 32'h0, "irq masked");
        wr_chk(IRQ_MASK_ADDR, 32'h4, RESP_OKAY);
        check({31'h0, irq}, 32'h1, "irq overflow");
        rd_chk(IRQ_STATUS_ADDR, 32'h5, RESP_OKAY);
        check({31'h0, irq}, 32'h0, "irq cleared");
        for (int i = 1; i <= 15; i++)
            rd_chk(ERROR_POP_ADDR, 32'(i), RESP_OKAY);
        rd_chk(ERROR_POP_ADDR, 32'hfffffebe, RESP_OKAY);
        rd_chk(ERROR_POP_ADDR, 32'h0, RESP_OKAY);
        wr_chk(ERROR_PUSH_ADDR, 32'h8000, RESP_OKAY);
        wr_chk(DRIVE_MODE_ADDR, 32'h2, RESP_OKAY);
        rd_chk(DRIVE_MODE_ADDR, 32'h0, RESP_OKAY);
        rd_chk(ERROR_COUNT_ADDR, 32'h2, RESP_OKAY);
        rd_chk(IRQ_MASK_ADDR, 32'h4, RESP_OKAY);
        rd_chk(ERROR_POP_ADDR, 32'hffff8000, RESP_OKAY);
        rd_chk(ERROR_POP_ADDR, 32'hffffff9e, RESP_OKAY);
        $display("test error queue done");
        summarize();
    end
endmodule
